//--- slpc_top.sv
// Function
// R1 - in asynchronous mode a set receive polarity bit inverts the incoming data line.
// R2 - the receive polarity bit never affects the synchronous data line.
// R3 - in asynchronous mode a set transmit polarity bit inverts the transmit output.
// R4 - in synchronous mode the transmit polarity bit inverts the shift clock line.
// R5 - bit 5 is a read/write receive polarity select clearing at reset; bit 4 is tx polarity.
// R6 - bit 2 ignores writes and always reads zero.
// R7 - in asynchronous mode, with transmit inversion on, the idle level between frames is inverted too.
module slpc_top (
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic clk_en_i,
  // axi4-lite slave
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // core side
  input wire logic core_tx_data_i,
  input wire logic core_tx_idle_i,
  input wire logic core_shift_clk_i,
  input wire logic core_sync_dt_out_i,
  input wire logic core_sync_dt_oe_i,
  input wire logic core_rx_idle_i,
  input wire logic core_rollover_i,
  output logic core_rx_data_o,
  output logic core_sync_dt_in_o,
  output logic core_wide_div_o,
  output logic core_wake_o,
  output logic core_autobaud_o,
  output logic core_sync_mode_o,
  // pins
  input wire logic rx_pin_i,
  output logic tx_pin_o,
  input wire logic sync_data_line_i,
  output logic sync_data_line_o,
  output logic sync_data_line_oe_o,
  input wire logic sync_shift_clock_line_i,
  output logic sync_shift_clock_line_o,
  output logic sync_shift_clock_line_oe_o
);
  logic [7:0] baud_reg;
  logic sync_mode_reg;
  logic aw_held_reg;
  logic w_held_reg;
  logic [3:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic rx_sync;
  logic dt_sync;
  logic ck_sync;
  logic rx_inv;
  logic tx_inv;
  logic do_write;
  logic [7:0] status_view;

  assign rx_inv = baud_reg[slpc_pkg::RX_INV_BIT];
  assign tx_inv = baud_reg[slpc_pkg::TX_INV_BIT];
  assign do_write = aw_held_reg && w_held_reg && !s_axi_bvalid;

  // ==========================================================
  // pin synchronisers
  slpc_sync2 u_rx_sync (
    .sys_clk_i(sys_clk_i),
    .resetn_i(resetn_i),
    .clk_en_i(clk_en_i),
    .d_i(rx_pin_i),
    .q_o(rx_sync)
  );
  slpc_sync2 u_dt_sync (
    .sys_clk_i(sys_clk_i),
    .resetn_i(resetn_i),
    .clk_en_i(clk_en_i),
    .d_i(sync_data_line_i),
    .q_o(dt_sync)
  );
  slpc_sync2 u_ck_sync (
    .sys_clk_i(sys_clk_i),
    .resetn_i(resetn_i),
    .clk_en_i(clk_en_i),
    .d_i(sync_shift_clock_line_i),
    .q_o(ck_sync)
  );

  // ==========================================================
  // axi write address / data capture, either order
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= 4'h0;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
    end else if (clk_en_i) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end else if (do_write) begin
        aw_held_reg <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end else if (do_write) begin
        w_held_reg <= 1'b0;
      end
    end
  end

  // ready while nothing held and no write response pending
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else if (clk_en_i) begin
      s_axi_awready <= !aw_held_reg && !(s_axi_awvalid && s_axi_awready)
                       && !s_axi_bvalid;
      s_axi_wready <= !w_held_reg && !(s_axi_wvalid && s_axi_wready)
                      && !s_axi_bvalid;
    end
  end

  // ==========================================================
  // register write and write response
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      baud_reg <= slpc_pkg::BAUD_CTRL_RESET;
      sync_mode_reg <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= slpc_pkg::RESP_OKAY;
    end else if (clk_en_i) begin
      // hardware status bits follow core
      baud_reg[slpc_pkg::RX_IDLE_BIT] <= core_rx_idle_i;
      baud_reg[slpc_pkg::ROLLOVER_BIT] <= core_rollover_i;
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= slpc_pkg::RESP_OKAY;
        if (awaddr_reg == slpc_pkg::BAUD_CTRL_OFFSET) begin
          if (wstrb_reg[0]) begin
            // writable bits only; bit 2 stays zero
            baud_reg[5:0] <= (wdata_reg[5:0] & slpc_pkg::BAUD_CTRL_WMASK[5:0]); // R5 R6
          end
        end else if (awaddr_reg == slpc_pkg::MODE_CTRL_OFFSET) begin
          if (wstrb_reg[0]) begin
            sync_mode_reg <= wdata_reg[slpc_pkg::SYNC_MODE_BIT];
          end
        end else if (awaddr_reg != slpc_pkg::LINE_STATUS_OFFSET) begin
          s_axi_bresp <= slpc_pkg::RESP_SLVERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ==========================================================
  // read channel
  assign status_view = {5'h00, ck_sync, dt_sync, rx_sync}; // line levels as seen on the wires
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= slpc_pkg::RESP_OKAY;
    end else if (clk_en_i) begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= slpc_pkg::RESP_OKAY;
        case (s_axi_araddr)
          slpc_pkg::BAUD_CTRL_OFFSET: s_axi_rdata <= {24'h000000, baud_reg};
          slpc_pkg::LINE_STATUS_OFFSET: s_axi_rdata <= {24'h000000, status_view};
          slpc_pkg::MODE_CTRL_OFFSET: s_axi_rdata <= {31'h0, sync_mode_reg};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= slpc_pkg::RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ==========================================================
  // receive path polarity
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      core_rx_data_o <= 1'b1;
      core_sync_dt_in_o <= 1'b1;
    end else if (clk_en_i) begin
      core_rx_data_o <= rx_sync ^ (rx_inv && !sync_mode_reg); // R1
      core_sync_dt_in_o <= dt_sync; // R2
    end
  end

  // ==========================================================
  // transmit and shift clock polarity
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tx_pin_o <= 1'b1;
      sync_data_line_o <= 1'b0;
      sync_data_line_oe_o <= 1'b0;
      sync_shift_clock_line_o <= 1'b0;
      sync_shift_clock_line_oe_o <= 1'b0;
    end else if (clk_en_i) begin
      if (core_tx_idle_i) begin
        tx_pin_o <= !tx_inv || sync_mode_reg; // R7
      end else begin
        tx_pin_o <= core_tx_data_i ^ (tx_inv && !sync_mode_reg); // R3
      end
      sync_data_line_o <= core_sync_dt_out_i; // R2
      sync_data_line_oe_o <= sync_mode_reg && core_sync_dt_oe_i;
      sync_shift_clock_line_o <= core_shift_clk_i ^ tx_inv; // R4
      sync_shift_clock_line_oe_o <= sync_mode_reg;
    end
  end

  // ==========================================================
  // config outputs to core
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      core_wide_div_o <= 1'b0;
      core_wake_o <= 1'b0;
      core_autobaud_o <= 1'b0;
      core_sync_mode_o <= 1'b0;
    end else if (clk_en_i) begin
      core_wide_div_o <= baud_reg[slpc_pkg::WIDE_DIV_BIT];
      core_wake_o <= baud_reg[slpc_pkg::WAKE_BIT];
      core_autobaud_o <= baud_reg[slpc_pkg::AUTOBAUD_BIT];
      core_sync_mode_o <= sync_mode_reg;
    end
  end

  // ==========================================================
  // checks
  chk_rx_invert: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // R1
    clk_en_i && $past(clk_en_i) && !sync_mode_reg && rx_inv && $stable(rx_inv) |=>
    !clk_en_i || core_rx_data_o == !$past(rx_sync))
    else $error("rx data not inverted");
  chk_sync_dt_pass: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // R2
    clk_en_i |=> !clk_en_i || core_sync_dt_in_o == $past(dt_sync))
    else $error("sync data altered");
  chk_tx_invert: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // R3
    clk_en_i && !sync_mode_reg && !core_tx_idle_i |=>
    tx_pin_o == ($past(core_tx_data_i) ^ $past(tx_inv)))
    else $error("tx polarity wrong");
  chk_clk_invert: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // R4
    clk_en_i |=> sync_shift_clock_line_o == ($past(core_shift_clk_i) ^ $past(tx_inv)))
    else $error("shift clock polarity wrong");
  chk_unimpl_zero: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // R6
    s_axi_rvalid && $rose(s_axi_rvalid) && $past(s_axi_araddr) == slpc_pkg::BAUD_CTRL_OFFSET
    |-> s_axi_rdata[slpc_pkg::UNIMPL_BIT] == 1'b0)
    else $error("unimplemented bit read as one");
  chk_rx_pol_rw: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // R5
    clk_en_i && do_write && awaddr_reg == slpc_pkg::BAUD_CTRL_OFFSET && wstrb_reg[0]
    |=> rx_inv == $past(wdata_reg[slpc_pkg::RX_INV_BIT]))
    else $error("rx polarity bit not written");
  chk_idle_level: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // R7
    clk_en_i && core_tx_idle_i && !sync_mode_reg |=> tx_pin_o == !$past(tx_inv))
    else $error("idle level wrong");
  chk_bresp_once: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
endmodule

//--- slpc_pkg.sv
package slpc_pkg;
  // ==========================================================
  // register map
  localparam logic [3:0] BAUD_CTRL_OFFSET = 4'h0;
  localparam logic [3:0] LINE_STATUS_OFFSET = 4'h4;
  localparam logic [7:0] BAUD_CTRL_RESET = 8'h40;
  localparam logic [7:0] BAUD_CTRL_WMASK = 8'h3B;
  // ==========================================================
  // field positions inside baud_rate_control
  localparam int ROLLOVER_BIT = 7;
  localparam int RX_IDLE_BIT = 6;
  localparam int RX_INV_BIT = 5;
  localparam int TX_INV_BIT = 4;
  localparam int WIDE_DIV_BIT = 3;
  localparam int UNIMPL_BIT = 2;
  localparam int WAKE_BIT = 1;
  localparam int AUTOBAUD_BIT = 0;
  // ==========================================================
  // mode control register fields
  localparam logic [3:0] MODE_CTRL_OFFSET = 4'h8;
  localparam int SYNC_MODE_BIT = 0;
  // ==========================================================
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

//--- slpc_sync2.sv
module slpc_sync2 (
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic clk_en_i,
  input wire logic d_i,
  output logic q_o
);
  logic meta_reg;
  // ==========================================================
  // two stage synchroniser, resets to the idle high level of the pins
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      meta_reg <= 1'b1;
      q_o <= 1'b1;
    end else if (clk_en_i) begin
      meta_reg <= d_i;
      q_o <= meta_reg;
    end
  end
endmodule

//--- slpc_remote.sv
// ==========================================================
// far serial device: drives rx and data lines, shares the wires
module slpc_remote (
  input wire logic sys_clk_i,
  input wire logic send_i,
  input wire logic dt_send_i,
  input wire logic dut_dt_i,
  input wire logic dut_dt_oe_i,
  input wire logic dut_ck_i,
  input wire logic dut_ck_oe_i,
  output logic rx_line_o,
  output logic dt_line_o,
  output logic ck_line_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic dt_q;
  // line levels change just after an edge
  always_ff @(posedge sys_clk_i) begin
    rx_line_o <= send_i;
    dt_q <= dt_send_i;
  end
  // wire level from the design's enable alone; remote clock stands idle high
  assign dt_line_o = dut_dt_oe_i ? dut_dt_i : dt_q;
  assign ck_line_o = dut_ck_oe_i ? dut_ck_i : 1'b1;
endmodule

//--- test_serial_line_polarity_control.sv
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin err_count++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module test_serial_line_polarity_control;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // stimulus and observed signals
  logic sys_clk_i = 1'b0, resetn_i = 1'b0, clk_en_i = 1'b1;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic core_tx_data_i = 1'b0, core_tx_idle_i = 1'b1, core_shift_clk_i = 1'b0;
  logic core_sync_dt_out_i = 1'b0, core_sync_dt_oe_i = 1'b0, core_rx_idle_i = 1'b1;
  logic core_rollover_i = 1'b0, rx_send = 1'b1, dt_send = 1'b1;
  logic core_rx_data_o, core_sync_dt_in_o, core_wide_div_o, core_wake_o, core_autobaud_o;
  logic core_sync_mode_o, rx_pin_i, tx_pin_o, sync_data_line_i, sync_data_line_o;
  logic sync_data_line_oe_o, sync_shift_clock_line_i, sync_shift_clock_line_o;
  logic sync_shift_clock_line_oe_o;
  int err_count = 0, n_compared = 0;
  // free-running clock
  always #5 sys_clk_i = ~sys_clk_i;
  slpc_top DUT (.sys_clk_i, .resetn_i, .clk_en_i, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .core_tx_data_i,
    .core_tx_idle_i, .core_shift_clk_i, .core_sync_dt_out_i, .core_sync_dt_oe_i,
    .core_rx_idle_i, .core_rollover_i, .core_rx_data_o, .core_sync_dt_in_o,
    .core_wide_div_o, .core_wake_o, .core_autobaud_o, .core_sync_mode_o, .rx_pin_i,
    .tx_pin_o, .sync_data_line_i, .sync_data_line_o, .sync_data_line_oe_o,
    .sync_shift_clock_line_i, .sync_shift_clock_line_o, .sync_shift_clock_line_oe_o);
  slpc_remote far (.sys_clk_i, .send_i(rx_send), .dt_send_i(dt_send),
    .dut_dt_i(sync_data_line_o), .dut_dt_oe_i(sync_data_line_oe_o),
    .dut_ck_i(sync_shift_clock_line_o), .dut_ck_oe_i(sync_shift_clock_line_oe_o),
    .rx_line_o(rx_pin_i), .dt_line_o(sync_data_line_i), .ck_line_o(sync_shift_clock_line_i));
  // ==========================================================
  // register bus cycles
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    @(posedge sys_clk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw && w)) begin
      @(posedge sys_clk_i);
      aw |= s_axi_awready;
      w |= s_axi_wready;
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end
    do @(posedge sys_clk_i); while (!s_axi_bvalid);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rchk(input string nm, input logic [3:0] a, input logic [31:0] e,
                      input logic [1:0] er);
    @(posedge sys_clk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge sys_clk_i); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge sys_clk_i); while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
    `CHK(nm, e, rd)
    `CHK("rresp", er, rs)
  endtask
  // ==========================================================
  // scenarios
  task automatic t_regs;
    rchk("baud after reset", 4'h0, 32'h40, slpc_pkg::RESP_OKAY);
    core_rollover_i <= 1'b1;
    wr(4'h0, 8'hFF);
    rchk("baud all ones", 4'h0, 32'hFB, slpc_pkg::RESP_OKAY);
    `CHK("core bits", 3'h7, {core_wide_div_o, core_wake_o, core_autobaud_o})
    wr(4'h0, 8'h04);
    rchk("baud bit2 only", 4'h0, 32'hC0, slpc_pkg::RESP_OKAY);
    wr(4'hC, 8'h55);
    `CHK("unmapped bresp", slpc_pkg::RESP_SLVERR, rs)
    rchk("unmapped read", 4'hC, 32'h0, slpc_pkg::RESP_SLVERR);
    core_rollover_i <= 1'b0;
  endtask
  task automatic t_rx;
    for (int i = 0; i < 4; i++) begin
      wr(4'h0, {2'b0, i[1], 5'b0});
      rx_send <= i[0];
      repeat (6) @(posedge sys_clk_i);
      `CHK("async rx", i[0] ^ i[1], core_rx_data_o)
    end
  endtask
  task automatic t_sync;
    wr(4'h8, 8'h01);
    wr(4'h0, 8'h20);
    `CHK("sync mode", 1'b1, core_sync_mode_o)
    for (int i = 0; i < 2; i++) begin
      dt_send <= i[0];
      rx_send <= i[0];
      repeat (6) @(posedge sys_clk_i);
      `CHK("sync dt in", i[0], core_sync_dt_in_o)
      `CHK("sync rx", i[0], core_rx_data_o)
    end
    for (int i = 0; i < 4; i++) begin
      wr(4'h0, {3'b0, i[1], 4'b0});
      core_shift_clk_i <= i[0];
      repeat (2) @(posedge sys_clk_i);
      `CHK("shift clock", i[0] ^ i[1], sync_shift_clock_line_o)
      `CHK("shift clock oe", 1'b1, sync_shift_clock_line_oe_o)
    end
    // design drives the shared data line, remote stays high
    core_sync_dt_oe_i <= 1'b1;
    core_sync_dt_out_i <= 1'b0;
    dt_send <= 1'b1;
    repeat (6) @(posedge sys_clk_i);
    `CHK("dt drive", 2'b10, {sync_data_line_oe_o, sync_data_line_o})
    `CHK("dt readback", 1'b0, core_sync_dt_in_o)
    rchk("line status", 4'h4, 32'h1, slpc_pkg::RESP_OKAY);
    rchk("mode readback", 4'h8, 32'h1, slpc_pkg::RESP_OKAY);
    // clock enable low must freeze the shift clock output
    clk_en_i <= 1'b0;
    core_shift_clk_i <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    `CHK("frozen clock", 1'b0, sync_shift_clock_line_o)
    clk_en_i <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    `CHK("released clock", 1'b1, sync_shift_clock_line_o)
  endtask
  task automatic t_tx;
    wr(4'h8, 8'h00);
    for (int i = 0; i < 8; i++) begin
      wr(4'h0, {3'b0, i[2], 4'b0});
      core_tx_idle_i <= i[1];
      core_tx_data_i <= i[0];
      repeat (2) @(posedge sys_clk_i);
      `CHK("tx pin", (i[1] | i[0]) ^ i[2], tx_pin_o)
    end
    `CHK("async clock oe", 1'b0, sync_shift_clock_line_oe_o)
    `CHK("async dt oe", 1'b0, sync_data_line_oe_o)
  endtask
  // mid-run reset clears both polarity selects
  task automatic t_reset;
    wr(4'h0, 8'h30);
    resetn_i <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    `CHK("reset tx pin", 1'b1, tx_pin_o)
    `CHK("reset rx data", 1'b1, core_rx_data_o)
    resetn_i <= 1'b1;
    rchk("baud after rerun", 4'h0, 32'h40, slpc_pkg::RESP_OKAY);
  endtask
  // ==========================================================
  // verdict
  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // main sequence after two reset cycles
  initial begin
    repeat (2) @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    t_regs;
    t_rx;
    t_sync;
    t_tx;
    t_reset;
    final_report;
  end
  // watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge sys_clk_i);
    err_count++;
    final_report;
  end
endmodule
